// file: epc_pkg.sv
// Package for the on-chip nonvolatile program/erase controller.
// Assumes a single synchronous clock domain and an 8-bit register port.
package epc_pkg;
   // Register addresses on the control port.
   localparam logic [15:0] EPC_ADDR_CONTROL    = 16'h103B;
   localparam logic [15:0] EPC_ADDR_PROTECT    = 16'h1035;
   localparam logic [15:0] EPC_ADDR_OPTION     = 16'h1039;
   localparam logic [15:0] EPC_ADDR_STATUS     = 16'h1030;
   localparam logic [15:0] EPC_ADDR_CONFIG     = 16'h103F;
   localparam logic [15:0] EPC_ADDR_ARRAY_BASE = 16'hB600;
   localparam int          EPC_ARRAY_BYTES     = 512;
   localparam int          EPC_ROW_BYTES       = 16;
   // Control register bit positions.
   localparam int EPC_BIT_VOLT  = 0;
   localparam int EPC_BIT_LATCH = 1;
   localparam int EPC_BIT_ERASE = 2;
   localparam int EPC_BIT_ROW   = 3;
   localparam int EPC_BIT_BYTE  = 4;
   localparam logic [7:0] EPC_CONTROL_MASK = 8'h1F;
   // Protect register layout and reset value, and the option register pump clock bit.
   localparam int          EPC_BIT_CFG_PROT = 4;
   localparam logic [4:0]  EPC_PROTECT_RESET = 5'h1F;
   localparam int          EPC_BIT_PUMP_CLK = 6;
   // Protect bits may be cleared only in this many cycles after reset, or at any time in special mode.
   localparam int          EPC_PROTECT_WINDOW = 64;
   localparam logic [7:0]  EPC_ERASED_BYTE = 8'hFF;
   localparam logic [7:0]  EPC_ZERO_BYTE   = 8'h00;
   // Status register bits.
   localparam int EPC_BIT_ST_HV     = 0;
   localparam int EPC_BIT_ST_ARMED  = 1;
   localparam int EPC_BIT_ST_SECURE = 2;
   localparam int EPC_BIT_ST_EXT    = 3;

   typedef enum logic [2:0] {
      EPC_IDLE  = 3'b001,
      EPC_SETUP = 3'b010,
      EPC_ARMED = 3'b100
   } epc_state_type;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } epc_bus_type;
endpackage

// file: epc_ctrl.sv
// Program/erase controller for an on-chip nonvolatile array and its config word.
// Assumes a CPU port with one-cycle strobes; read data appear the cycle after a read.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module epc_ctrl
   import epc_pkg::*;
#(
   parameter int ARRAY_BYTES = EPC_ARRAY_BYTES
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire epc_bus_type bus,
   input  wire logic        special_mode,
   input  wire logic        secure_enable,
   input  wire logic        expanded_request,
   output logic [7:0]       rdata,
   output logic             high_voltage_on,
   output logic             pump_clock_select,
   output logic             expanded_mode
);
   localparam int AW = $clog2(ARRAY_BYTES);

   logic [7:0]    mem_r [ARRAY_BYTES];
   logic [7:0]    config_r;
   logic [4:0]    control_r;
   logic [4:0]    protect_r;
   logic          pump_clk_r;
   logic [6:0]    window_cnt_r;
   epc_state_type state_r;
   logic [AW-1:0] lat_addr_r;
   logic [7:0]    lat_data_r;
   logic          lat_cfg_r;
   logic [7:0]    rdata_r;
   logic          hv_r;
   logic          ext_r;

   logic          in_array;
   logic          in_cfg;
   logic [AW-1:0] off;
   logic [7:0]    wctl;
   logic          blk_prot;
   logic          hv_now;

   assign in_array = (bus.addr >= EPC_ADDR_ARRAY_BASE) &&
                     (bus.addr < EPC_ADDR_ARRAY_BASE + 16'(ARRAY_BYTES));
   assign in_cfg   = (bus.addr == EPC_ADDR_CONFIG);
   assign off      = AW'(bus.addr - EPC_ADDR_ARRAY_BASE);
   assign wctl     = bus.wdata & EPC_CONTROL_MASK;
   assign hv_now   = control_r[EPC_BIT_VOLT];

   // Block protect bit covering the latched offset (32/64/128/288-byte blocks).
   always_comb begin
      if (lat_addr_r < AW'(32)) begin
         blk_prot = protect_r[0];
      end else if (lat_addr_r < AW'(96)) begin
         blk_prot = protect_r[1];
      end else if (lat_addr_r < AW'(224)) begin
         blk_prot = protect_r[2];
      end else begin
         blk_prot = protect_r[3];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control register and arming sequence.
   // The voltage bit cannot be set by the same write that sets the latch, so a
   // stray single store can never reach high voltage.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         control_r <= 5'h00;
         state_r   <= EPC_IDLE;
      end else if (bus.wr && bus.addr == EPC_ADDR_CONTROL) begin
         if (wctl[EPC_BIT_LATCH] && wctl[EPC_BIT_VOLT]) begin
            if (state_r == EPC_ARMED) begin
               control_r <= wctl[4:0];
            end else begin
               control_r <= {wctl[4:2], 2'b00};
               state_r   <= EPC_IDLE;
            end
         end else if (wctl[EPC_BIT_LATCH]) begin
            control_r <= {wctl[4:1], 1'b0};
            if (!control_r[EPC_BIT_LATCH]) begin
               state_r <= EPC_SETUP;
            end
         end else begin
            control_r <= {wctl[4:1], 1'b0};
            state_r   <= EPC_IDLE;
         end
      end else if (bus.wr && control_r[EPC_BIT_LATCH] && (in_array || in_cfg) && !hv_now &&
                   state_r != EPC_IDLE) begin
         state_r <= EPC_ARMED;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Programming latches capture target address and data.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lat_addr_r <= '0;
         lat_data_r <= EPC_ERASED_BYTE;
         lat_cfg_r  <= 1'b0;
      end else if (bus.wr && control_r[EPC_BIT_LATCH] && !hv_now && (in_array || in_cfg)) begin
         lat_addr_r <= in_cfg ? '0 : off;
         lat_data_r <= bus.wdata;
         lat_cfg_r  <= in_cfg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Array and config cells. The operation is applied every cycle high voltage
   // is on; repeating it is harmless since erase and program are idempotent.
   genvar gi;
   generate
      for (gi = 0; gi < ARRAY_BYTES; gi++) begin : g_cell
         logic sel;
         always_comb begin
            if (control_r[EPC_BIT_BYTE]) begin
               sel = (AW'(gi) == lat_addr_r);
            end else if (control_r[EPC_BIT_ROW]) begin
               sel = (AW'(gi) / AW'(EPC_ROW_BYTES)) == (lat_addr_r / AW'(EPC_ROW_BYTES));
            end else begin
               sel = 1'b1;
            end
         end
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               mem_r[gi] <= EPC_ERASED_BYTE;
            end else if (hv_now && !lat_cfg_r && !blk_prot) begin
               if (control_r[EPC_BIT_ERASE] && sel) begin
                  mem_r[gi] <= EPC_ERASED_BYTE;
               end else if (!control_r[EPC_BIT_ERASE] && AW'(gi) == lat_addr_r) begin
                  mem_r[gi] <= mem_r[gi] & lat_data_r;
               end
            end
         end
      end
   endgenerate

   // Config word; touched only when the latched target is the config address.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         config_r <= EPC_ERASED_BYTE;
      end else if (hv_now && lat_cfg_r && !protect_r[EPC_BIT_CFG_PROT]) begin
         if (control_r[EPC_BIT_ERASE]) begin
            config_r <= EPC_ERASED_BYTE;
         end else begin
            config_r <= config_r & lat_data_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Protect register, pump clock select and early-reset window.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         window_cnt_r <= 7'h00;
         protect_r    <= EPC_PROTECT_RESET;
         pump_clk_r   <= 1'b0;
      end else begin
         if (window_cnt_r < 7'(EPC_PROTECT_WINDOW)) begin
            window_cnt_r <= window_cnt_r + 7'h01;
         end
         if (bus.wr && bus.addr == EPC_ADDR_PROTECT) begin
            if (special_mode || window_cnt_r < 7'(EPC_PROTECT_WINDOW)) begin
               protect_r <= bus.wdata[4:0];
            end else begin
               protect_r <= protect_r | bus.wdata[4:0];
            end
         end
         if (bus.wr && bus.addr == EPC_ADDR_OPTION) begin
            pump_clk_r <= bus.wdata[EPC_BIT_PUMP_CLK];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port, high-voltage flag and operating mode gate.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= EPC_ZERO_BYTE;
         hv_r    <= 1'b0;
         ext_r   <= 1'b0;
      end else begin
         hv_r  <= hv_now;
         ext_r <= expanded_request && !secure_enable;
         if (!bus.rd) begin
            rdata_r <= EPC_ZERO_BYTE;
         end else if (bus.addr == EPC_ADDR_CONTROL) begin
            rdata_r <= {3'b000, control_r};
         end else if (bus.addr == EPC_ADDR_PROTECT) begin
            rdata_r <= {3'b000, protect_r};
         end else if (bus.addr == EPC_ADDR_OPTION) begin
            rdata_r <= {1'b0, pump_clk_r, 6'h00};
         end else if (bus.addr == EPC_ADDR_STATUS) begin
            rdata_r <= {4'h0, ext_r, secure_enable, state_r == EPC_ARMED, hv_now};
         end else if (bus.addr == EPC_ADDR_CONFIG) begin
            rdata_r <= config_r;
         end else if (in_array && !control_r[EPC_BIT_LATCH]) begin
            rdata_r <= mem_r[off];
         end else begin
            rdata_r <= EPC_ZERO_BYTE;
         end
      end
   end

   assign rdata             = rdata_r;
   assign high_voltage_on   = hv_r;
   assign pump_clock_select = pump_clk_r;
   assign expanded_mode     = ext_r;
endmodule

// file: epc_ctrl_assertions.sv
// Port checker for the program/erase controller.
// Assumes one clock domain; bound to every epc_ctrl instance.
`timescale 1ns/1ps
module epc_ctrl_assertions
   import epc_pkg::*;
#(
   parameter int ARRAY_BYTES = EPC_ARRAY_BYTES
) (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire epc_bus_type bus,
   input wire logic        special_mode,
   input wire logic        secure_enable,
   input wire logic        expanded_request,
   input wire logic [7:0]  rdata,
   input wire logic        high_voltage_on,
   input wire logic        pump_clock_select,
   input wire logic        expanded_mode
);
   // One domain, so clock and reset are stated once.
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////
   // Decodes shared by the properties below.
   wire ctl_wr = bus.wr && bus.addr == EPC_ADDR_CONTROL;
   wire opt_wr = bus.wr && bus.addr == EPC_ADDR_OPTION;
   wire arr_rd = bus.rd && bus.addr >= EPC_ADDR_ARRAY_BASE && bus.addr < EPC_ADDR_ARRAY_BASE + ARRAY_BYTES;
   ////////////////////////////////////////////////////////////
   // The past guard keeps reset-time samples out of the first edge.
   read_idle_a: assert property ($past(arst_n) && !$past(bus.rd) |-> rdata == EPC_ZERO_BYTE)
      else $error("read data not idle");
   read_blocked_a: assert property ($past(arr_rd && high_voltage_on) |-> rdata == EPC_ZERO_BYTE)
      else $error("array readable while latched");
   hv_rise_a: assert property ($rose(high_voltage_on) |-> $past(ctl_wr && bus.wdata[1:0] == 2'b11, 2))
      else $error("voltage rose without arming write");
   hv_fall_a: assert property ($fell(high_voltage_on) |-> $past(ctl_wr, 2))
      else $error("voltage fell without control write");
   hv_clear_a: assert property (ctl_wr && !bus.wdata[EPC_BIT_VOLT] |-> ##2 !high_voltage_on)
      else $error("voltage stayed on after clear");
   exp_grant_a: assert property ($past(arst_n) && $past(expanded_request && !secure_enable) |-> expanded_mode)
      else $error("expanded mode not granted");
   exp_secure_a: assert property (secure_enable |=> !expanded_mode)
      else $error("expanded mode while secure");
   pump_hold_a: assert property ($past(arst_n) && !$past(opt_wr) |-> $stable(pump_clock_select))
      else $error("pump clock changed without write");
endmodule
bind epc_ctrl epc_ctrl_assertions #(.ARRAY_BYTES(ARRAY_BYTES)) chk_i (.clk(clk), .arst_n(arst_n), .bus(bus),
   .special_mode(special_mode), .secure_enable(secure_enable), .expanded_request(expanded_request),
   .rdata(rdata), .high_voltage_on(high_voltage_on), .pump_clock_select(pump_clock_select),
   .expanded_mode(expanded_mode));

// file: test_epc_ctrl.sv
// Self-checking bench for the program/erase controller.
// Assumes the controller alone, driven over its register port.
`timescale 1ns/1ps
module test_epc_ctrl;
   import epc_pkg::*;
   localparam epc_bus_type IDLE = '0;
   localparam logic [7:0] MODES [6] = '{8'h03, 8'h1B, 8'h07, 8'h0F, 8'h17, 8'h1F};
   logic        clk;
   logic        arst_n;
   epc_bus_type bus;
   logic        special_mode;
   logic        secure_enable;
   logic        expanded_request;
   logic [7:0]  rdata;
   logic        high_voltage_on;
   logic        pump_clock_select;
   logic        expanded_mode;
   logic [7:0]  mem [EPC_ARRAY_BYTES];
   logic [7:0]  cfg;
   logic [15:0] a;
   int          seed = 32'h0999B93A;
   int          n_errors = 0;
   int          total_checks = 0;
   epc_ctrl uut (.clk(clk), .arst_n(arst_n), .bus(bus), .special_mode(special_mode), .secure_enable(secure_enable),
      .expanded_request(expanded_request), .rdata(rdata), .high_voltage_on(high_voltage_on),
      .pump_clock_select(pump_clock_select), .expanded_mode(expanded_mode));
   // Free-running 4 ns clock.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////
   // Bus tasks; the caller starts each just after a rising edge.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] ad, input logic [7:0] d);
      bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
   endtask
   task automatic rd(input logic [15:0] ad, input logic [7:0] exp);
      bus <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= IDLE;
      #1 chk(rdata, exp);
      @(posedge clk);
   endtask
   task automatic nop(input int n);
      bus <= IDLE;
      repeat (n) @(posedge clk);
   endtask
   // Expected cell contents after one completed operation.
   function automatic void model(input logic [7:0] c, input logic [15:0] ad, input logic [7:0] d);
      int o;
      o = int'(ad - EPC_ADDR_ARRAY_BASE);
      if (ad == EPC_ADDR_CONFIG) cfg = c[EPC_BIT_ERASE] ? EPC_ERASED_BYTE : cfg & d;
      else if (!c[EPC_BIT_ERASE]) mem[o] = mem[o] & d;
      else if (c[EPC_BIT_BYTE]) mem[o] = EPC_ERASED_BYTE;
      else for (int i = 0; i < EPC_ARRAY_BYTES; i++)
         if (!c[EPC_BIT_ROW] || i / EPC_ROW_BYTES == o / EPC_ROW_BYTES) mem[i] = EPC_ERASED_BYTE;
   endfunction
   task automatic check_all;
      for (int i = 0; i < EPC_ARRAY_BYTES; i++) rd(EPC_ADDR_ARRAY_BASE + 16'(i), mem[i]);
      rd(EPC_ADDR_CONFIG, cfg);
   endtask
   // Full sequence; reads while latched must be blocked.
   task automatic op(input logic [7:0] c, input logic [15:0] ad, input logic [7:0] d);
      wr(EPC_ADDR_CONTROL, c & 8'hFE);
      wr(ad, d);
      rd(EPC_ADDR_ARRAY_BASE, EPC_ZERO_BYTE);
      wr(EPC_ADDR_CONTROL, c);
      nop(3);
      #1 chk({7'h00, high_voltage_on}, 8'h01);
      // Reads while the voltage is on must stay blocked; status shows armed and high voltage.
      rd(EPC_ADDR_ARRAY_BASE + 16'h0100, EPC_ZERO_BYTE);
      rd(EPC_ADDR_STATUS, 8'h03);
      wr(EPC_ADDR_CONTROL, 8'h00);
      nop(3);
      #1 chk({7'h00, high_voltage_on}, 8'h00);
      model(c, ad, d);
      check_all;
      $display("op %h at %h done", c, ad);
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence; protect clears must land in the early window unless special mode is set.
   initial begin
      arst_n = 1'b0;
      bus = IDLE;
      special_mode = 1'b0;
      secure_enable = 1'b0;
      expanded_request = 1'b0;
      cfg = EPC_ERASED_BYTE;
      foreach (mem[i]) mem[i] = EPC_ERASED_BYTE;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rd(EPC_ADDR_PROTECT, {3'b000, EPC_PROTECT_RESET});
      wr(EPC_ADDR_PROTECT, 8'h00);
      wr(EPC_ADDR_OPTION, 8'h40);
      nop(1);
      #1 chk({7'h00, pump_clock_select}, 8'h01);
      rd(EPC_ADDR_PROTECT, 8'h00);
      check_all;
      wr(EPC_ADDR_CONTROL, 8'h03);
      nop(3);
      #1 chk({7'h00, high_voltage_on}, 8'h00);
      rd(EPC_ADDR_CONTROL, 8'h00);
      $display("reset and arming tests done");
      op(8'h03, EPC_ADDR_ARRAY_BASE + 16'h0010, 8'h5A);
      op(8'h03, EPC_ADDR_ARRAY_BASE + 16'h0010, 8'h0F);
      op(8'h1F, EPC_ADDR_ARRAY_BASE + 16'h0010, 8'h00);
      op(8'h03, EPC_ADDR_ARRAY_BASE + 16'h0010, 8'hC3);
      op(8'h03, EPC_ADDR_CONFIG, 8'hA5);
      op(8'h17, EPC_ADDR_CONFIG, 8'h00);
      op(8'h03, EPC_ADDR_CONFIG, 8'h3C);
      op(8'h0F, EPC_ADDR_ARRAY_BASE + 16'h0025, 8'h00);
      op(8'h07, EPC_ADDR_ARRAY_BASE + 16'h01FF, 8'h00);
      repeat (10) begin
         a = ($random(seed) & 3) == 0 ? EPC_ADDR_CONFIG : EPC_ADDR_ARRAY_BASE + 16'($random(seed) & 32'h1FF);
         op(MODES[$unsigned($random(seed)) % 6], a, 8'($random(seed)));
      end
      for (int k = 0; k < 4; k++) begin
         secure_enable <= k[0];
         expanded_request <= k[1];
         nop(2);
         #1 chk({7'h00, expanded_mode}, {7'h00, k[1] & ~k[0]});
      end
      wr(EPC_ADDR_PROTECT, 8'h1F);
      wr(EPC_ADDR_PROTECT, 8'h00);
      rd(EPC_ADDR_PROTECT, 8'h1F);
      special_mode <= 1'b1;
      wr(EPC_ADDR_PROTECT, 8'h00);
      rd(EPC_ADDR_PROTECT, 8'h00);
      rd(16'h2000, 8'h00);
      $display("mode and protect tests done");
      close_out;
   end
   // A hang beyond the expected run counts as a mismatch.
   initial begin
      #400000;
      n_errors++;
      close_out;
   end
endmodule
